/* File: logic/ddr_sram_pkg.sv */
// shared constants and types for the split-port ddr burst memory link
package ddr_sram_pkg;
  localparam int DATA_W = 36;
  localparam int ADDR_W = 17;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int BURST = 4;
  localparam int BEAT_W = 2;
  localparam int WIDX_W = ADDR_W + BEAT_W;
  localparam int MEM_WORDS = 1 << WIDX_W;
  localparam int BURST_W = DATA_W * BURST;
  localparam int MASK_W = LANES * BURST;
  // controller clocking: link clock made by dividing mclk
  localparam int MCLK_PERIOD_NS = 5;
  localparam int K_PERIOD_NS = 20;
  localparam int K_HALF_CYC = K_PERIOD_NS / (2 * MCLK_PERIOD_NS);
  localparam logic [1:0] PH_LAST = 2'(2 * K_HALF_CYC - 1);
  localparam logic [1:0] PH_HI_UPD = 2'h0;
  localparam logic [1:0] PH_LO_UPD = 2'(K_HALF_CYC);
  // single-cycle mode is only legal up to this link frequency
  localparam int BYPASS_FMAX_MHZ = 167;
  localparam logic [3:0] LANE_SEL_NONE = 4'hF;
  localparam logic PLL_BYPASS_RST = 1'h1;

  typedef enum logic {
    SLOT_RD = 1'b0,
    SLOT_WR = 1'b1
  } slot_e;
endpackage

/* File: logic/ddr_sram_if.sv */
// pin-level link between memory controller and burst memory
interface ddr_sram_if;
  logic k;
  logic kn;
  logic [ddr_sram_pkg::ADDR_W-1:0] addr;
  logic read_port_select_n;
  logic write_port_select_n;
  logic [ddr_sram_pkg::LANES-1:0] byte_write_select_n;
  logic [ddr_sram_pkg::DATA_W-1:0] d;
  logic [ddr_sram_pkg::DATA_W-1:0] q;
  logic q_oe;
  wire [ddr_sram_pkg::DATA_W-1:0] q_pin;
  logic output_valid_flag;
  logic echo_timing_pair_p;
  logic echo_timing_pair_n;
  logic pll_bypass_n;

  // released read bus shows the inverted word, so stale data never looks valid
  assign q_pin = q_oe ? q : ~q;

  modport dev (
    input k, kn, addr, read_port_select_n, write_port_select_n,
    input byte_write_select_n, d, pll_bypass_n,
    output q, q_oe, output_valid_flag, echo_timing_pair_p, echo_timing_pair_n
  );
  modport ctrl (
    output k, kn, addr, read_port_select_n, write_port_select_n,
    output byte_write_select_n, d, pll_bypass_n,
    input q_pin, output_valid_flag, echo_timing_pair_p, echo_timing_pair_n
  );
endinterface

/* File: logic/ddr_sram_device.sv */
// burst memory end: ddr write port, ddr read port, shared address bus
// Notes on behaviour
// - write data captured both clock rises during writes
// - low write select starts write unless read select is low too; high ignores
// - only selected lanes of a word stored
// - each select covers one nine-bit lane
// - lane selects sampled with their data word
// - shared address sampled on true clock rise
// - seventeen-bit address picks four-word burst
// - address ignored when owning port deselected
// - read data launched on both clock rises
// - low read select starts read, high deselects
// - bus floats after pending burst and K
// - each read returns four sequential words
// - valid flag marks data, aligned with echo
// - every access starts on true clock rise
// - complement rise also captures and launches data
// - free-running echo clocks follow true clock
// - bypass pin low selects single-cycle latency
module ddr_sram_device (
  input wire logic rstn_i,
  ddr_sram_if.dev link,
  output logic bypass_active_o
);
  localparam int DW = ddr_sram_pkg::DATA_W;
  localparam int AW = ddr_sram_pkg::ADDR_W;
  localparam int IW = ddr_sram_pkg::WIDX_W;

  logic [DW-1:0] mem [0:ddr_sram_pkg::MEM_WORDS-1];

  function automatic logic [DW-1:0] merge_lanes(
    input logic [DW-1:0] old_w,
    input logic [DW-1:0] new_w,
    input logic [ddr_sram_pkg::LANES-1:0] sel_n
  );
    logic [DW-1:0] res;
    res = old_w;
    for (int i = 0; i < ddr_sram_pkg::LANES; i++) begin
      if (!sel_n[i]) begin
        res[i*ddr_sram_pkg::LANE_W +: ddr_sram_pkg::LANE_W] =
          new_w[i*ddr_sram_pkg::LANE_W +: ddr_sram_pkg::LANE_W];
      end
    end
    return res;
  endfunction

  function automatic logic [IW-1:0] word_idx(
    input logic [AW-1:0] adr,
    input logic [1:0] beat
  );
    return {adr, beat};
  endfunction

  // bypass pin: three flops, change taken once last two agree
  logic byp_s1_reg;
  logic byp_s2_reg;
  logic byp_s3_reg;
  logic byp_reg;

  always_ff @(posedge link.k or negedge rstn_i) begin
    if (!rstn_i) begin
      byp_s1_reg <= ddr_sram_pkg::PLL_BYPASS_RST;
      byp_s2_reg <= ddr_sram_pkg::PLL_BYPASS_RST;
      byp_s3_reg <= ddr_sram_pkg::PLL_BYPASS_RST;
      byp_reg <= 1'b0;
    end else begin
      byp_s1_reg <= link.pll_bypass_n;
      byp_s2_reg <= byp_s1_reg;
      byp_s3_reg <= byp_s2_reg;
      if (byp_s2_reg == byp_s3_reg) begin
        byp_reg <= !byp_s3_reg;
      end
    end
  end

  assign bypass_active_o = byp_reg;

  // address cycle ownership: read port has it when both are selected
  logic rd_take;
  logic wr_take;
  assign rd_take = !link.read_port_select_n;
  assign wr_take = !link.write_port_select_n && link.read_port_select_n;

  // write pipeline
  logic wr0_reg;
  logic wr2_reg;
  logic [AW-1:0] wadr0_reg;
  logic [AW-1:0] wadr2_reg;
  logic pend_reg;
  logic [IW-1:0] pend_idx_reg;
  logic [DW-1:0] dkn_reg;
  logic [ddr_sram_pkg::LANES-1:0] bkn_reg;

  always_ff @(posedge link.k or negedge rstn_i) begin
    if (!rstn_i) begin
      wr0_reg <= 1'b0;
      wr2_reg <= 1'b0;
      wadr0_reg <= '0;
      wadr2_reg <= '0;
      pend_reg <= 1'b0;
      pend_idx_reg <= '0;
    end else begin
      wr0_reg <= wr_take;
      if (wr_take) begin
        wadr0_reg <= link.addr;
      end
      wr2_reg <= wr0_reg;
      wadr2_reg <= wadr0_reg;
      pend_reg <= wr0_reg || wr2_reg;
      pend_idx_reg <= wr0_reg ? word_idx(wadr0_reg, 2'h1) : word_idx(wadr2_reg, 2'h3);
    end
  end

  // complement-edge capture of odd beats, only inside a write burst
  always_ff @(posedge link.kn or negedge rstn_i) begin
    if (!rstn_i) begin
      dkn_reg <= '0;
      bkn_reg <= ddr_sram_pkg::LANE_SEL_NONE;
    end else if (pend_reg) begin
      dkn_reg <= link.d;
      bkn_reg <= link.byte_write_select_n;
    end
  end

  // even beats are stored straight from the pins on the true edge
  always_ff @(posedge link.k) begin
    if (pend_reg) begin
      mem[pend_idx_reg] <= merge_lanes(mem[pend_idx_reg], dkn_reg, bkn_reg);
    end
    if (wr0_reg) begin
      mem[word_idx(wadr0_reg, 2'h0)] <= merge_lanes(mem[word_idx(wadr0_reg, 2'h0)],
        link.d, link.byte_write_select_n);
    end
    if (wr2_reg) begin
      mem[word_idx(wadr2_reg, 2'h2)] <= merge_lanes(mem[word_idx(wadr2_reg, 2'h2)],
        link.d, link.byte_write_select_n);
    end
  end

  // read pipeline: one stage per true-clock cycle
  logic p1v_reg;
  logic p2v_reg;
  logic p3v_reg;
  logic p4v_reg;
  logic [AW-1:0] p1a_reg;
  logic [AW-1:0] p2a_reg;
  logic [AW-1:0] p3a_reg;
  logic [AW-1:0] p4a_reg;

  always_ff @(posedge link.k or negedge rstn_i) begin
    if (!rstn_i) begin
      p1v_reg <= 1'b0;
      p2v_reg <= 1'b0;
      p3v_reg <= 1'b0;
      p4v_reg <= 1'b0;
      p1a_reg <= '0;
      p2a_reg <= '0;
      p3a_reg <= '0;
      p4a_reg <= '0;
    end else begin
      p1v_reg <= rd_take;
      if (rd_take) begin
        p1a_reg <= link.addr;
      end
      p2v_reg <= p1v_reg;
      p2a_reg <= p1a_reg;
      p3v_reg <= p2v_reg;
      p3a_reg <= p2a_reg;
      p4v_reg <= p3v_reg;
      p4a_reg <= p3a_reg;
    end
  end

  // launch registers: true-edge word, staged complement-edge word
  logic [DW-1:0] qk_reg;
  logic vk_reg;
  logic [DW-1:0] knst_reg;
  logic knv_reg;
  logic oe_reg;
  logic [DW-1:0] qkn_reg;
  logic vkn_reg;

  always_ff @(posedge link.k or negedge rstn_i) begin
    if (!rstn_i) begin
      qk_reg <= '0;
      vk_reg <= 1'b0;
      knst_reg <= '0;
      knv_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      vk_reg <= 1'b0;
      knv_reg <= 1'b0;
      if (byp_reg) begin
        if (p1v_reg) begin
          qk_reg <= mem[word_idx(p1a_reg, 2'h0)];
          vk_reg <= 1'b1;
          knst_reg <= mem[word_idx(p1a_reg, 2'h1)];
          knv_reg <= 1'b1;
        end
        if (p2v_reg) begin
          qk_reg <= mem[word_idx(p2a_reg, 2'h2)];
          vk_reg <= 1'b1;
          knst_reg <= mem[word_idx(p2a_reg, 2'h3)];
          knv_reg <= 1'b1;
        end
        oe_reg <= p1v_reg || p2v_reg;
      end else begin
        if (p2v_reg) begin
          knst_reg <= mem[word_idx(p2a_reg, 2'h0)];
          knv_reg <= 1'b1;
        end
        if (p3v_reg) begin
          qk_reg <= mem[word_idx(p3a_reg, 2'h1)];
          vk_reg <= 1'b1;
          knst_reg <= mem[word_idx(p3a_reg, 2'h2)];
          knv_reg <= 1'b1;
        end
        if (p4v_reg) begin
          qk_reg <= mem[word_idx(p4a_reg, 2'h3)];
          vk_reg <= 1'b1;
        end
        oe_reg <= p2v_reg || p3v_reg || p4v_reg;
      end
    end
  end

  always_ff @(posedge link.kn or negedge rstn_i) begin
    if (!rstn_i) begin
      qkn_reg <= '0;
      vkn_reg <= 1'b0;
    end else begin
      qkn_reg <= knst_reg;
      vkn_reg <= knv_reg;
    end
  end

  // ddr output: true-half shows the true-edge flop, low half the other
  assign link.q = link.k ? qk_reg : qkn_reg;
  assign link.output_valid_flag = link.k ? vk_reg : vkn_reg;
  assign link.q_oe = oe_reg;
  assign link.echo_timing_pair_p = link.k;
  assign link.echo_timing_pair_n = link.kn;
endmodule

/* File: logic/ddr_sram_ctrl.sv */
// controller end: makes the link clock, schedules bursts, gathers reads
module ddr_sram_ctrl (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic pll_bypass_n_i,
  input wire logic rd_req_i,
  input wire logic [ddr_sram_pkg::ADDR_W-1:0] rd_addr_i,
  output logic rd_ack_o,
  output logic [ddr_sram_pkg::BURST_W-1:0] rd_data_o,
  output logic rd_valid_o,
  input wire logic wr_req_i,
  input wire logic [ddr_sram_pkg::ADDR_W-1:0] wr_addr_i,
  input wire logic [ddr_sram_pkg::BURST_W-1:0] wr_data_i,
  input wire logic [ddr_sram_pkg::MASK_W-1:0] wr_mask_n_i,
  output logic wr_ack_o,
  ddr_sram_if.ctrl link
);
  localparam int DW = ddr_sram_pkg::DATA_W;
  localparam int LW = ddr_sram_pkg::LANES;

  function automatic logic [DW-1:0] data_beat(
    input logic [ddr_sram_pkg::BURST_W-1:0] w,
    input logic [1:0] b
  );
    return w[b*DW +: DW];
  endfunction

  function automatic logic [LW-1:0] mask_beat(
    input logic [ddr_sram_pkg::MASK_W-1:0] m,
    input logic [1:0] b
  );
    return m[b*LW +: LW];
  endfunction

  logic [1:0] ph_reg;
  logic k_reg;
  logic kn_reg;
  logic upd_hi;
  logic upd_lo;
  logic [1:0] ph_next;

  assign ph_next = (ph_reg == ddr_sram_pkg::PH_LAST) ? 2'h0 : ph_reg + 2'h1;
  assign upd_hi = ph_reg == ddr_sram_pkg::PH_HI_UPD;
  assign upd_lo = ph_reg == ddr_sram_pkg::PH_LO_UPD;

  // link clock divider; outputs change mid-half, away from both edges
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ph_reg <= ddr_sram_pkg::PH_LAST;
      k_reg <= 1'b0;
      kn_reg <= 1'b1;
    end else begin
      ph_reg <= ph_next;
      k_reg <= ph_next < 2'(ddr_sram_pkg::K_HALF_CYC);
      kn_reg <= !(ph_next < 2'(ddr_sram_pkg::K_HALF_CYC));
    end
  end

  // address slots alternate between read and write ports
  ddr_sram_pkg::slot_e slot_reg;
  logic [ddr_sram_pkg::ADDR_W-1:0] addr_reg;
  logic rsel_n_reg;
  logic wsel_n_reg;
  logic byp_n_reg;
  logic [ddr_sram_pkg::BURST_W-1:0] wnew_reg;
  logic [ddr_sram_pkg::MASK_W-1:0] mnew_reg;
  logic wnv_reg;
  logic wact_reg;
  logic [1:0] wstep_reg;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      slot_reg <= ddr_sram_pkg::SLOT_WR;
      addr_reg <= '0;
      rsel_n_reg <= 1'b1;
      wsel_n_reg <= 1'b1;
      byp_n_reg <= ddr_sram_pkg::PLL_BYPASS_RST;
      rd_ack_o <= 1'b0;
      wr_ack_o <= 1'b0;
      wnew_reg <= '0;
      mnew_reg <= '0;
      wnv_reg <= 1'b0;
    end else begin
      rd_ack_o <= 1'b0;
      wr_ack_o <= 1'b0;
      byp_n_reg <= pll_bypass_n_i;
      if (upd_hi && (!wact_reg || wstep_reg == 2'h3)) begin
        wnv_reg <= 1'b0;
      end
      if (upd_lo) begin
        rsel_n_reg <= 1'b1;
        wsel_n_reg <= 1'b1;
        if (slot_reg == ddr_sram_pkg::SLOT_WR) begin
          slot_reg <= ddr_sram_pkg::SLOT_RD;
          if (rd_req_i) begin
            rsel_n_reg <= 1'b0;
            addr_reg <= rd_addr_i;
            rd_ack_o <= 1'b1;
          end
        end else begin
          slot_reg <= ddr_sram_pkg::SLOT_WR;
          if (wr_req_i && !wnv_reg) begin
            wsel_n_reg <= 1'b0;
            addr_reg <= wr_addr_i;
            wnew_reg <= wr_data_i;
            mnew_reg <= wr_mask_n_i;
            wnv_reg <= 1'b1;
            wr_ack_o <= 1'b1;
          end
        end
      end
    end
  end

  // write beats: even beats before true rises, odd before complement rises
  logic [ddr_sram_pkg::BURST_W-1:0] wcur_reg;
  logic [ddr_sram_pkg::MASK_W-1:0] mcur_reg;
  logic [DW-1:0] d_reg;
  logic [LW-1:0] lane_sel_n_reg;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wact_reg <= 1'b0;
      wstep_reg <= 2'h0;
      wcur_reg <= '0;
      mcur_reg <= '0;
      d_reg <= '0;
      lane_sel_n_reg <= ddr_sram_pkg::LANE_SEL_NONE;
    end else if (upd_hi || upd_lo) begin
      d_reg <= '0;
      lane_sel_n_reg <= ddr_sram_pkg::LANE_SEL_NONE;
      if (wact_reg && (wstep_reg[0] == upd_hi)) begin
        d_reg <= data_beat(wcur_reg, wstep_reg);
        lane_sel_n_reg <= mask_beat(mcur_reg, wstep_reg);
        wstep_reg <= wstep_reg + 2'h1;
        if (wstep_reg == 2'h3) begin
          wact_reg <= 1'b0;
        end
      end
      if (upd_hi && wnv_reg && (!wact_reg || wstep_reg == 2'h3)) begin
        wcur_reg <= wnew_reg;
        mcur_reg <= mnew_reg;
        wstep_reg <= 2'h0;
        wact_reg <= 1'b1;
      end
    end
  end

  // read capture: sampled one mclk after each launch edge
  logic [1:0] rcnt_reg;
  logic [ddr_sram_pkg::BURST_W-1:0] rbuf_reg;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rcnt_reg <= 2'h0;
      rbuf_reg <= '0;
      rd_data_o <= '0;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= 1'b0;
      if ((upd_hi || upd_lo) && link.output_valid_flag) begin
        rbuf_reg[rcnt_reg*DW +: DW] <= link.q_pin;
        rcnt_reg <= rcnt_reg + 2'h1;
        if (rcnt_reg == 2'h3) begin
          rd_data_o <= {link.q_pin, rbuf_reg[3*DW-1:0]};
          rd_valid_o <= 1'b1;
        end
      end
    end
  end

  assign link.k = k_reg;
  assign link.kn = kn_reg;
  assign link.addr = addr_reg;
  assign link.read_port_select_n = rsel_n_reg;
  assign link.write_port_select_n = wsel_n_reg;
  assign link.byte_write_select_n = lane_sel_n_reg;
  assign link.d = d_reg;
  assign link.pll_bypass_n = byp_n_reg;
endmodule

/* File: bench/ddr_sram_asserts.sv */
// concurrent checks on the memory link, sampled on the controller clock
module ddr_sram_asserts (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic k,
  input wire logic kn,
  input wire logic read_port_select_n,
  input wire logic write_port_select_n,
  input wire logic [ddr_sram_pkg::LANES-1:0] byte_write_select_n,
  input wire logic [ddr_sram_pkg::DATA_W-1:0] d,
  input wire logic q_oe,
  input wire logic output_valid_flag,
  input wire logic echo_timing_pair_p,
  input wire logic echo_timing_pair_n,
  input wire logic pll_bypass_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  a_echo_follows_k: assert property (echo_timing_pair_p == k && echo_timing_pair_n == kn)
    else $error("echo clocks differ from link clock");
  a_echo_free_run: assert property ($changed(echo_timing_pair_p)
    |=> !$changed(echo_timing_pair_p) ##1 $changed(echo_timing_pair_p))
    else $error("echo clock not toggling each half period");
  a_kn_inverse: assert property (kn == !k)
    else $error("complement clock not inverse");
  a_valid_needs_oe: assert property (output_valid_flag |-> q_oe)
    else $error("valid flag while read bus floats");
  a_read_normal: assert property ($rose(k) && !read_port_select_n && pll_bypass_n
    && $past(pll_bypass_n, 16) |-> ##[8:12] output_valid_flag)
    else $error("read data late in normal mode");
  a_read_bypass: assert property ($rose(k) && !read_port_select_n && !pll_bypass_n
    && !$past(pll_bypass_n, 16) |-> ##[3:6] output_valid_flag)
    else $error("read data late in bypass mode");
  a_burst_len: assert property ($rose(output_valid_flag) |-> output_valid_flag[*6])
    else $error("read burst too short");
  a_oe_released: assert property (q_oe && !output_valid_flag
    |-> ##[1:6] (output_valid_flag || !q_oe))
    else $error("read bus driven without data");
  a_rsel_period: assert property ($fell(read_port_select_n)
    |-> !read_port_select_n[*4] ##1 read_port_select_n)
    else $error("read select not one link period");
  a_wsel_period: assert property ($fell(write_port_select_n)
    |-> !write_port_select_n[*4] ##1 write_port_select_n)
    else $error("write select not one link period");
  a_slots_apart: assert property (!read_port_select_n |-> write_port_select_n)
    else $error("both port selects low together");
  a_write_beats: assert property ((byte_write_select_n != ddr_sram_pkg::LANE_SEL_NONE || d != '0)
    |-> (!$past(write_port_select_n, 4) || !$past(write_port_select_n, 8)))
    else $error("write beat outside a write burst");
endmodule

/* File: bench/tb_top.sv */
// testbench: controller and memory joined back to back, random traffic
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [ddr_sram_pkg::ADDR_W-1:0] adr_t;
  typedef logic [ddr_sram_pkg::BURST_W-1:0] word_t;
  typedef logic [ddr_sram_pkg::MASK_W-1:0] mask_t;
  localparam int AN = 6;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic pll_bypass_n_i = 1'b1;
  logic rd_req = 1'b0;
  adr_t rd_addr = '0;
  logic rd_ack;
  word_t rd_data;
  logic rd_valid;
  logic wr_req = 1'b0;
  adr_t wr_addr = '0;
  word_t wr_data = '0;
  mask_t wr_mask_n = '1;
  logic wr_ack;
  logic bypass_active;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  word_t model [adr_t];
  adr_t adr [AN];

  always #2.5 mclk_i = ~mclk_i;

  ddr_sram_if ddr_sram_if_inst ();
  ddr_sram_ctrl ddr_sram_ctrl_inst (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .pll_bypass_n_i(pll_bypass_n_i), .rd_req_i(rd_req), .rd_addr_i(rd_addr),
    .rd_ack_o(rd_ack), .rd_data_o(rd_data), .rd_valid_o(rd_valid), .wr_req_i(wr_req),
    .wr_addr_i(wr_addr), .wr_data_i(wr_data), .wr_mask_n_i(wr_mask_n), .wr_ack_o(wr_ack),
    .link(ddr_sram_if_inst));
  ddr_sram_device ddr_sram_device_inst (.rstn_i(rstn_i), .link(ddr_sram_if_inst),
    .bypass_active_o(bypass_active));
  ddr_sram_asserts ddr_sram_asserts_inst (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .k(ddr_sram_if_inst.k), .kn(ddr_sram_if_inst.kn),
    .read_port_select_n(ddr_sram_if_inst.read_port_select_n),
    .write_port_select_n(ddr_sram_if_inst.write_port_select_n),
    .byte_write_select_n(ddr_sram_if_inst.byte_write_select_n), .d(ddr_sram_if_inst.d),
    .q_oe(ddr_sram_if_inst.q_oe), .output_valid_flag(ddr_sram_if_inst.output_valid_flag),
    .echo_timing_pair_p(ddr_sram_if_inst.echo_timing_pair_p),
    .echo_timing_pair_n(ddr_sram_if_inst.echo_timing_pair_n),
    .pll_bypass_n(ddr_sram_if_inst.pll_bypass_n));

  // lane i of the flat burst sits at bit 9*i
  function automatic word_t merge(input word_t old_w, input word_t new_w, input mask_t m);
    merge = old_w;
    for (int i = 0; i < ddr_sram_pkg::MASK_W; i++) begin
      if (!m[i]) merge[i*ddr_sram_pkg::LANE_W +: ddr_sram_pkg::LANE_W] = new_w[i*9 +: 9];
    end
  endfunction

  function automatic word_t rnd_word();
    rnd_word = word_t'({$urandom, $urandom, $urandom, $urandom, $urandom});
  endfunction

  // 0: write ack, 1: read ack, 2: read data valid
  function automatic logic pick(input int sel);
    return (sel == 0) ? wr_ack : (sel == 1) ? rd_ack : rd_valid;
  endfunction

  task automatic wait_hi(input int sel);
    int n;
    n = 0;
    do begin
      @(negedge mclk_i);
      n++;
    end while (pick(sel) !== 1'b1 && n < 40);
  endtask

  task automatic wr(input adr_t a, input word_t w, input mask_t m);
    @(negedge mclk_i);
    wr_addr = a;
    wr_data = w;
    wr_mask_n = m;
    wr_req = 1'b1;
    wait_hi(0);
    wr_req = 1'b0;
    checks++;
    if (wr_ack !== 1'b1) begin
      n_fail++;
      $display("unexpected at %0t: no write ack", $time);
    end
    model[a] = merge(model.exists(a) ? model[a] : w, w, m);
    repeat (16) @(negedge mclk_i);
  endtask

  task automatic rd(input adr_t a);
    @(negedge mclk_i);
    rd_addr = a;
    rd_req = 1'b1;
    wait_hi(1);
    rd_req = 1'b0;
    wait_hi(2);
    checks++;
    if (rd_valid !== 1'b1 || rd_data !== model[a]) begin
      n_fail++;
      $display("unexpected at %0t: read data of %h", $time, a);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      $display("unexpected at %0t: run took too long", $time);
      report_and_stop();
    end
  end

  initial begin
    void'($urandom(32'h18FFC653));
    repeat (10) @(negedge mclk_i);
    rstn_i = 1'b1;
    for (int i = 0; i < AN; i++) begin
      adr[i] = (i == 0) ? '0 : (i == 1) ? '1 : adr_t'($urandom);
      wr(adr[i], rnd_word(), '0);
    end
    for (int i = 0; i < AN; i++) rd(adr[i]);
    for (int j = 0; j < 12; j++) begin
      wr(adr[j % AN], rnd_word(), (j == 0) ? '1 : (j == 1) ? 16'h7FFE : mask_t'($urandom));
      rd(adr[j % AN]);
    end
    for (int j = 0; j < 4; j++) begin
      fork
        wr(adr[0], rnd_word(), mask_t'($urandom));
        rd(adr[1]);
      join
    end
    rd(adr[0]);
    pll_bypass_n_i = 1'b0;
    repeat (20) @(negedge mclk_i);
    checks++;
    if (bypass_active !== 1'b1) begin
      n_fail++;
      $display("unexpected at %0t: bypass mode not active", $time);
    end
    wr(adr[2], rnd_word(), mask_t'($urandom));
    for (int i = 0; i < AN; i++) rd(adr[i]);
    report_and_stop();
  end
endmodule
